// ### rtl/wgc_top.sv
`timescale 1ns/10ps
module wgc_top (
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic TRIGGER_N_I,
    input wire logic PATTERN_END_I,
    input wire logic [13:0] MEM_DATA_I,
    input wire logic [13:0] DDS_SAMPLE_I,
    output logic MARKER_O,
    output logic MARKER_OE_N_O,
    output logic [13:0] SAMPLE_O,
    output logic [11:0] GAIN_O,
    output logic [23:0] TUNING_WORD_O,
    output logic [15:0] PHASE_O,
    output logic COS_SELECT_O,
    output logic SRAM_CLK_SEL_O,
    output logic START_DELAY_EN_O
);
    // ---------------- Bus slave and register file ----------------
    wgc_pkg::wgc_regs_s regs_q, regs_d;
    wgc_pkg::wgc_phase_s ph_q, ph_d;
    logic hready_q, hready_d;
    logic [31:0] rdata_q, rdata_d;
    logic resp_q;
    logic [13:0] code_q, code_d;
    logic marker_q, marker_d;
    logic [15:0] rd_val;
    logic addr_ok;

    assign addr_ok = (HADDR_I[31:10] == 22'h000000) && (HADDR_I[1:0] == 2'h0)
                     && (HSIZE_I == wgc_pkg::HSIZE_WORD);

    always_comb begin
        regs_d = regs_q;
        ph_d = ph_q;
        hready_d = 1'b1;
        rdata_d = rdata_q;
        rd_val = 16'h0000;
        case (ph_q.idx)
            wgc_pkg::IDX_PIN_CTRL: rd_val = regs_q.pin_ctrl;
            wgc_pkg::IDX_WAVE_CFG: rd_val = regs_q.wave_cfg;
            wgc_pkg::IDX_MARK_START: rd_val = regs_q.mark_start;
            wgc_pkg::IDX_MARK_CFG: rd_val = regs_q.mark_cfg;
            wgc_pkg::IDX_CONST: rd_val = regs_q.const_val;
            wgc_pkg::IDX_GAIN: rd_val = regs_q.gain;
            wgc_pkg::IDX_RAMP_CFG: rd_val = regs_q.ramp_cfg;
            wgc_pkg::IDX_TW_HIGH: rd_val = regs_q.tw_high;
            wgc_pkg::IDX_TW_LOW: rd_val = regs_q.tw_low;
            wgc_pkg::IDX_PHASE: rd_val = regs_q.phase;
            wgc_pkg::IDX_TRIG_CTL: rd_val = regs_q.trig_ctl;
            wgc_pkg::IDX_SYNTH_CFG: rd_val = regs_q.synth_cfg;
            wgc_pkg::IDX_MERGE_CFG: rd_val = regs_q.merge_cfg;
            wgc_pkg::IDX_STATUS: rd_val = {1'b0, marker_q, code_q};
            default: rd_val = 16'h0000;
        endcase
        // Writes land at the end of their zero-wait data phase.
        if (ph_q.valid && ph_q.write) begin
            case (ph_q.idx)
                wgc_pkg::IDX_PIN_CTRL: regs_d.pin_ctrl = HWDATA_I[15:0];
                wgc_pkg::IDX_WAVE_CFG: regs_d.wave_cfg = HWDATA_I[15:0];
                wgc_pkg::IDX_MARK_START: regs_d.mark_start = HWDATA_I[15:0];
                wgc_pkg::IDX_MARK_CFG: regs_d.mark_cfg = HWDATA_I[15:0];
                wgc_pkg::IDX_CONST: regs_d.const_val = HWDATA_I[15:0];
                wgc_pkg::IDX_GAIN: regs_d.gain = HWDATA_I[15:0];
                wgc_pkg::IDX_RAMP_CFG: regs_d.ramp_cfg = HWDATA_I[15:0];
                wgc_pkg::IDX_TW_HIGH: regs_d.tw_high = HWDATA_I[15:0];
                wgc_pkg::IDX_TW_LOW: regs_d.tw_low = HWDATA_I[15:0];
                wgc_pkg::IDX_PHASE: regs_d.phase = HWDATA_I[15:0];
                wgc_pkg::IDX_TRIG_CTL: regs_d.trig_ctl = HWDATA_I[15:0];
                wgc_pkg::IDX_SYNTH_CFG: regs_d.synth_cfg = HWDATA_I[15:0];
                wgc_pkg::IDX_MERGE_CFG: regs_d.merge_cfg = HWDATA_I[15:0];
                default: regs_d = regs_q;
            endcase
        end
        // A read takes one wait state so a write just before it is always seen.
        if (ph_q.valid && !ph_q.write && !hready_q) begin
            rdata_d = {16'h0000, rd_val};
            ph_d.valid = 1'b0;
        end else if (ph_q.valid && !ph_q.write) begin
            hready_d = 1'b0;
        end else begin
            ph_d.valid = 1'b0;
        end
        if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
            ph_d.valid = addr_ok;
            ph_d.write = HWRITE_I;
            ph_d.idx = HADDR_I[9:2];
            if (!addr_ok) begin
                rdata_d = 32'h00000000;
            end else if (!HWRITE_I) begin
                hready_d = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            regs_q <= wgc_pkg::REGS_RST;
            ph_q <= '0;
            hready_q <= 1'b1;
            rdata_q <= 32'h00000000;
            resp_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            ph_q <= ph_d;
            hready_q <= hready_d;
            rdata_q <= rdata_d;
            resp_q <= 1'b0;
        end
    end

    assign HRDATA_O = rdata_q;
    assign HREADYOUT_O = hready_q;
    assign HRESP_O = resp_q;

    // ---------------- Trigger synchroniser and marker sequencer ----------------
    logic trig_s1_q, trig_s2_q, trig_s3_q, trig_lvl_q, trig_lvl_d;
    logic trig_fall;
    wgc_pkg::wgc_mark_e mk_q, mk_d;
    logic [15:0] mk_cnt_q, mk_cnt_d;
    logic oe_n_q, oe_n_d;
    logic first_pend_q, first_pend_d;
    logic dly_en_q, dly_en_d;
    logic pin_en, auto_mode;
    logic [3:0] stop_dly;

    assign pin_en = regs_q.pin_ctrl[wgc_pkg::PIN_EN_BIT];
    assign auto_mode = regs_q.mark_cfg[wgc_pkg::MARK_MODE_BIT];
    assign stop_dly = regs_q.mark_cfg[wgc_pkg::MARK_STOP_MSB:0];
    // Stage one feeds only stage two; a change counts once stages two and three agree.
    assign trig_fall = trig_lvl_q && (trig_s2_q == trig_s3_q) && !trig_s2_q;

    always_comb begin
        trig_lvl_d = (trig_s2_q == trig_s3_q) ? trig_s2_q : trig_lvl_q;
        mk_d = mk_q;
        mk_cnt_d = mk_cnt_q;
        case (mk_q)
            wgc_pkg::MK_IDLE: begin
                if (trig_fall) begin
                    mk_d = (regs_q.mark_start <= 16'h0001) ? wgc_pkg::MK_HIGH
                                                           : wgc_pkg::MK_START_WAIT;
                    mk_cnt_d = regs_q.mark_start - 16'h0001;
                end
            end
            wgc_pkg::MK_START_WAIT: begin
                if (mk_cnt_q <= 16'h0001) begin
                    mk_d = wgc_pkg::MK_HIGH;
                end
                mk_cnt_d = mk_cnt_q - 16'h0001;
            end
            wgc_pkg::MK_HIGH: begin
                if (PATTERN_END_I) begin
                    mk_d = (stop_dly <= 4'h1) ? wgc_pkg::MK_IDLE : wgc_pkg::MK_STOP_WAIT;
                    mk_cnt_d = {12'h000, stop_dly} - 16'h0001;
                end
            end
            wgc_pkg::MK_STOP_WAIT: begin
                if (mk_cnt_q <= 16'h0001) begin
                    mk_d = wgc_pkg::MK_IDLE;
                end
                mk_cnt_d = mk_cnt_q - 16'h0001;
            end
            default: mk_d = wgc_pkg::MK_IDLE;
        endcase
        // With a zero stop delay the marker falls one cycle after the end, the same as with a stop delay of one.
        if (mk_q == wgc_pkg::MK_HIGH && PATTERN_END_I && stop_dly == 4'h0) begin
            mk_d = wgc_pkg::MK_IDLE;
        end
        if (!pin_en) begin
            marker_d = 1'b0;
        end else if (!auto_mode) begin
            marker_d = regs_q.mark_cfg[wgc_pkg::MARK_LEVEL_BIT];
        end else begin
            marker_d = (mk_d == wgc_pkg::MK_HIGH) || (mk_d == wgc_pkg::MK_STOP_WAIT);
        end
        oe_n_d = !pin_en;
        // Set by a trigger wins over a clear by the same-cycle pattern end.
        first_pend_d = trig_fall ? 1'b1 : (PATTERN_END_I ? 1'b0 : first_pend_q);
        dly_en_d = !regs_q.trig_ctl[wgc_pkg::FIRST_ONLY_BIT] || first_pend_d;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            trig_s1_q <= 1'b1;
            trig_s2_q <= 1'b1;
            trig_s3_q <= 1'b1;
            trig_lvl_q <= 1'b1;
            mk_q <= wgc_pkg::MK_IDLE;
            mk_cnt_q <= 16'h0000;
            marker_q <= 1'b0;
            oe_n_q <= 1'b1;
            first_pend_q <= 1'b0;
            dly_en_q <= 1'b1;
        end else begin
            trig_s1_q <= TRIGGER_N_I;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            trig_lvl_q <= trig_lvl_d;
            mk_q <= mk_d;
            mk_cnt_q <= mk_cnt_d;
            marker_q <= marker_d;
            oe_n_q <= oe_n_d;
            first_pend_q <= first_pend_d;
            dly_en_q <= dly_en_d;
        end
    end

    assign MARKER_O = marker_q;
    assign MARKER_OE_N_O = oe_n_q;
    assign START_DELAY_EN_O = dly_en_q;

    // ---------------- Waveform sources and synthesizer controls ----------------
    logic [5:0] step_cnt_q, step_cnt_d;
    logic dir_down_q, dir_down_d;
    logic [13:0] prbs_q, prbs_d;
    logic [13:0] sample_q, sample_d;
    logic [23:0] tw_q, tw_d;
    logic [15:0] phase_q, phase_d;
    logic [11:0] gain_q;
    logic cos_q, sram_clk_q;
    logic [5:0] step_len;
    logic [4:0] shift;
    logic [23:0] tw_regs, tw_mask, tw_mem;
    wgc_pkg::wgc_shape_e shape;
    wgc_pkg::wgc_src_e src;

    assign shape = wgc_pkg::wgc_shape_e'(regs_q.ramp_cfg[wgc_pkg::RAMP_SHAPE_MSB:0]);
    assign src = wgc_pkg::wgc_src_e'(regs_q.wave_cfg[wgc_pkg::PRESTORE_MSB:wgc_pkg::PRESTORE_LSB]);
    // A zero step field would stall the ramp, so it holds for one sample instead.
    assign step_len = (regs_q.ramp_cfg[wgc_pkg::RAMP_STEP_MSB:wgc_pkg::RAMP_STEP_LSB] == 6'h00)
                      ? 6'h01 : regs_q.ramp_cfg[wgc_pkg::RAMP_STEP_MSB:wgc_pkg::RAMP_STEP_LSB];
    assign tw_regs = {regs_q.tw_high, regs_q.tw_low[15:wgc_pkg::TW_LOW_LSB]};
    // Shift codes past the last defined one are reserved and clamp to it.
    assign shift = (regs_q.merge_cfg[wgc_pkg::MERGE_SHIFT_MSB:0] > wgc_pkg::MERGE_SHIFT_MAX)
                   ? wgc_pkg::MERGE_SHIFT_MAX : regs_q.merge_cfg[wgc_pkg::MERGE_SHIFT_MSB:0];
    assign tw_mask = ~(24'hFFFFFF >> shift);
    assign tw_mem = (tw_regs & tw_mask) | ({MEM_DATA_I, 10'h000} >> shift);

    always_comb begin
        step_cnt_d = step_cnt_q;
        code_d = code_q;
        dir_down_d = dir_down_q;
        if (shape == wgc_pkg::RAMP_ZERO) begin
            code_d = 14'h0000;
            step_cnt_d = 6'h00;
        end else if (step_cnt_q + 6'h01 >= step_len) begin
            step_cnt_d = 6'h00;
            case (shape)
                wgc_pkg::RAMP_UP: code_d = code_q + 14'h0001;
                wgc_pkg::RAMP_DOWN: code_d = code_q - 14'h0001;
                wgc_pkg::RAMP_TRI: begin
                    if (!dir_down_q && code_q == wgc_pkg::RAMP_TOP) begin
                        dir_down_d = 1'b1;
                        code_d = code_q - 14'h0001;
                    end else if (dir_down_q && code_q == 14'h0000) begin
                        dir_down_d = 1'b0;
                        code_d = code_q + 14'h0001;
                    end else begin
                        code_d = dir_down_q ? code_q - 14'h0001 : code_q + 14'h0001;
                    end
                end
                default: code_d = 14'h0000;
            endcase
        end else begin
            step_cnt_d = step_cnt_q + 6'h01;
        end
        prbs_d = {prbs_q[12:0], prbs_q[13] ^ prbs_q[12] ^ prbs_q[11] ^ prbs_q[1]};
        case (src)
            wgc_pkg::SRC_CONST: sample_d = {regs_q.const_val[15:wgc_pkg::FIELD12_LSB], 2'h0};
            wgc_pkg::SRC_RAMP: sample_d = code_q;
            wgc_pkg::SRC_PRBS: sample_d = prbs_q;
            wgc_pkg::SRC_SYNTH: sample_d = DDS_SAMPLE_I;
            default: sample_d = 14'h0000;
        endcase
        tw_d = regs_q.synth_cfg[wgc_pkg::TW_MEM_BIT] ? tw_mem : tw_regs;
        phase_d = regs_q.synth_cfg[wgc_pkg::PHASE_MEM_BIT] ? {MEM_DATA_I, 2'h0}
                                                           : regs_q.phase;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            step_cnt_q <= 6'h00;
            code_q <= 14'h0000;
            dir_down_q <= 1'b0;
            prbs_q <= wgc_pkg::RST_PRBS;
            sample_q <= 14'h0000;
            tw_q <= 24'h000000;
            phase_q <= 16'h0000;
            gain_q <= 12'h000;
            cos_q <= 1'b0;
            sram_clk_q <= 1'b0;
        end else begin
            step_cnt_q <= step_cnt_d;
            code_q <= code_d;
            dir_down_q <= dir_down_d;
            prbs_q <= prbs_d;
            sample_q <= sample_d;
            tw_q <= tw_d;
            phase_q <= phase_d;
            gain_q <= regs_q.gain[15:wgc_pkg::FIELD12_LSB];
            cos_q <= regs_q.synth_cfg[wgc_pkg::COS_BIT];
            sram_clk_q <= regs_q.synth_cfg[wgc_pkg::SRAM_CLK_BIT];
        end
    end

    assign SAMPLE_O = sample_q;
    assign TUNING_WORD_O = tw_q;
    assign PHASE_O = phase_q;
    assign GAIN_O = gain_q;
    assign COS_SELECT_O = cos_q;
    assign SRAM_CLK_SEL_O = sram_clk_q;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_auto_armed;
        pin_en && auto_mode && mk_q == wgc_pkg::MK_IDLE && trig_fall;
    endsequence
    sequence s_rise_after_three;
        ##1 !MARKER_O [*2] ##1 MARKER_O;
    endsequence

    AST_MARKER_MANUAL: assert property (
        (pin_en && !auto_mode) |=> MARKER_O == $past(regs_q.mark_cfg[wgc_pkg::MARK_LEVEL_BIT])
    ) else $error("Manual marker level not driven.");
    AST_PIN_DISABLED: assert property (
        !pin_en |=> (!MARKER_O && MARKER_OE_N_O)
    ) else $error("Marker pin active while disabled.");
    AST_PIN_DRIVEN: assert property (
        pin_en |=> !MARKER_OE_N_O
    ) else $error("Marker pin not driven while enabled.");
    AST_MARK_RISE: assert property (
        (s_auto_armed and (regs_q.mark_start == 16'h0003)) |-> s_rise_after_three
    ) else $error("Marker did not rise three cycles after trigger.");
    AST_MARK_FALL: assert property (
        (pin_en && auto_mode && mk_q == wgc_pkg::MK_HIGH && PATTERN_END_I && stop_dly == 4'h4)
        |-> ##1 MARKER_O [*3] ##1 !MARKER_O
    ) else $error("Marker did not fall four cycles after pattern end.");
    AST_RAMP_HOLD: assert property (
        ($changed(code_q) && shape == wgc_pkg::RAMP_UP && step_len == 6'h04 && $stable(regs_q))
        |=> $stable(code_q) [*3] ##1 (code_q == $past(code_q) + 14'h0001)
    ) else $error("Ramp step length wrong.");
    AST_RAMP_ZERO: assert property (
        shape == wgc_pkg::RAMP_ZERO |=> code_q == 14'h0000
    ) else $error("Zero ramp shape not zero.");
    AST_TW_REGS: assert property (
        !regs_q.synth_cfg[wgc_pkg::TW_MEM_BIT] |=> TUNING_WORD_O == $past(tw_regs)
    ) else $error("Tuning word not taken from registers.");
    AST_PHASE_SRC: assert property (
        regs_q.synth_cfg[wgc_pkg::PHASE_MEM_BIT] |=> PHASE_O == {$past(MEM_DATA_I), 2'h0}
    ) else $error("Phase not taken from memory.");
    AST_SRC_CONST: assert property (
        src == wgc_pkg::SRC_CONST |=> SAMPLE_O == {$past(regs_q.const_val[15:4]), 2'h0}
    ) else $error("Constant source not selected.");
    AST_DELAY_EVERY: assert property (
        !regs_q.trig_ctl[wgc_pkg::FIRST_ONLY_BIT] |=> START_DELAY_EN_O
    ) else $error("Start delay not applied to every pattern.");
endmodule : wgc_top

// ### rtl/wgc_pkg.sv
package wgc_pkg;
    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_PIN_CTRL = 8'h00;
    localparam logic [7:0] IDX_WAVE_CFG = 8'h27;
    localparam logic [7:0] IDX_MARK_START = 8'h2C;
    localparam logic [7:0] IDX_MARK_CFG = 8'h2D;
    localparam logic [7:0] IDX_CONST = 8'h31;
    localparam logic [7:0] IDX_GAIN = 8'h35;
    localparam logic [7:0] IDX_RAMP_CFG = 8'h37;
    localparam logic [7:0] IDX_TW_HIGH = 8'h3E;
    localparam logic [7:0] IDX_TW_LOW = 8'h3F;
    localparam logic [7:0] IDX_PHASE = 8'h43;
    localparam logic [7:0] IDX_TRIG_CTL = 8'h44;
    localparam logic [7:0] IDX_SYNTH_CFG = 8'h45;
    localparam logic [7:0] IDX_MERGE_CFG = 8'h47;
    localparam logic [7:0] IDX_STATUS = 8'h70;

    // Field positions.
    localparam int PIN_EN_BIT = 0;
    localparam int MARK_LEVEL_BIT = 5;
    localparam int MARK_MODE_BIT = 4;
    localparam int MARK_STOP_MSB = 3;
    localparam int FIELD12_LSB = 4;
    localparam int RAMP_STEP_MSB = 7;
    localparam int RAMP_STEP_LSB = 2;
    localparam int RAMP_SHAPE_MSB = 1;
    localparam int TW_LOW_LSB = 8;
    localparam int FIRST_ONLY_BIT = 1;
    localparam int COS_BIT = 3;
    localparam int SRAM_CLK_BIT = 2;
    localparam int PHASE_MEM_BIT = 1;
    localparam int TW_MEM_BIT = 0;
    localparam int PRESTORE_MSB = 5;
    localparam int PRESTORE_LSB = 4;
    localparam int MERGE_SHIFT_MSB = 4;
    localparam logic [4:0] MERGE_SHIFT_MAX = 5'h10;

    // Reset values, and the top code of the triangle ramp.
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_WAVE_CFG = 16'h0101;
    localparam logic [15:0] RST_MARK_START = 16'h0003;
    localparam logic [15:0] RST_RAMP_CFG = 16'h0104;
    localparam logic [13:0] RST_PRBS = 14'h0001;
    localparam logic [13:0] RAMP_TOP = 14'h3FFF;

    // Bus encodings.
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        MK_IDLE = 2'b00,
        MK_START_WAIT = 2'b01,
        MK_HIGH = 2'b10,
        MK_STOP_WAIT = 2'b11
    } wgc_mark_e;

    typedef enum logic [1:0] {
        RAMP_UP = 2'b00,
        RAMP_DOWN = 2'b01,
        RAMP_TRI = 2'b10,
        RAMP_ZERO = 2'b11
    } wgc_shape_e;

    typedef enum logic [1:0] {
        SRC_CONST = 2'b00,
        SRC_RAMP = 2'b01,
        SRC_PRBS = 2'b10,
        SRC_SYNTH = 2'b11
    } wgc_src_e;

    typedef struct packed {
        logic [15:0] pin_ctrl;
        logic [15:0] wave_cfg;
        logic [15:0] mark_start;
        logic [15:0] mark_cfg;
        logic [15:0] const_val;
        logic [15:0] gain;
        logic [15:0] ramp_cfg;
        logic [15:0] tw_high;
        logic [15:0] tw_low;
        logic [15:0] phase;
        logic [15:0] trig_ctl;
        logic [15:0] synth_cfg;
        logic [15:0] merge_cfg;
    } wgc_regs_s;

    localparam wgc_regs_s REGS_RST = '{
        pin_ctrl: RST_ZERO, wave_cfg: RST_WAVE_CFG, mark_start: RST_MARK_START,
        mark_cfg: RST_ZERO, const_val: RST_ZERO, gain: RST_ZERO,
        ramp_cfg: RST_RAMP_CFG, tw_high: RST_ZERO, tw_low: RST_ZERO,
        phase: RST_ZERO, trig_ctl: RST_ZERO, synth_cfg: RST_ZERO, merge_cfg: RST_ZERO
    };

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } wgc_phase_s;
endpackage : wgc_pkg

// ### verif/tb_wgc_top.sv
`timescale 1ns/10ps
module tb_wgc_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic trig_n = 1'b1;
    logic pend = 1'b0;
    logic [13:0] dds = 14'h1234;
    logic [13:0] mem = 14'h0000;
    logic [13:0] s0, s1;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic hready, hresp, mk, oe_n, cos, sclk, sde;
    logic [13:0] smp;
    logic [11:0] gain;
    logic [23:0] tw;
    logic [15:0] ph;
    int failures = 0;
    int total_checks = 0;
    int n;

    initial begin
        forever #4 clk = ~clk;
    end

    // The single slave's ready is the bus ready, as on a one-slave bus.
    wgc_top dut (.REF_CLK_I(clk), .SRST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(wgc_pkg::HSIZE_WORD),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .TRIGGER_N_I(trig_n), .PATTERN_END_I(pend), .MEM_DATA_I(mem),
        .DDS_SAMPLE_I(dds), .MARKER_O(mk), .MARKER_OE_N_O(oe_n), .SAMPLE_O(smp),
        .GAIN_O(gain), .TUNING_WORD_O(tw), .PHASE_O(ph), .COS_SELECT_O(cos),
        .SRAM_CLK_SEL_O(sclk), .START_DELAY_EN_O(sde));

    task print_verdict;
        $display("failures=%0d total_checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask : chk

    // Ready is looked at on the falling edge, so it is the value the next rising edge samples.
    task wait_rdy;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask : wait_rdy

    task bus(input logic w, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        wait_rdy();
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        wait_rdy();
        // Read data is taken at the edge that samples ready high.
        @(posedge clk);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] idx, input logic [15:0] wd);
        bus(1'b1, idx, wd);
    endtask : wr

    task rdchk(input string nm, input logic [7:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(nm, {16'h0, exp}, rd);
    endtask : rdchk

    task idle;
        repeat (3) @(negedge clk);
    endtask : idle

    task t_reset;
        rdchk("ramp_cfg", wgc_pkg::IDX_RAMP_CFG, 16'h0104);
        rdchk("mark_cfg", wgc_pkg::IDX_MARK_CFG, 16'h0000);
        rdchk("const", wgc_pkg::IDX_CONST, 16'h0000);
        rdchk("gain", wgc_pkg::IDX_GAIN, 16'h0000);
        rdchk("phase", wgc_pkg::IDX_PHASE, 16'h0000);
        rdchk("mark_start", wgc_pkg::IDX_MARK_START, 16'h0003);
        rdchk("wave_cfg", wgc_pkg::IDX_WAVE_CFG, 16'h0101);
        chk("delay_en", 32'h1, {31'h0, sde});
        chk("tw_rst", 32'h0, {8'h0, tw});
        chk("mk_rst", 32'h0, {31'h0, mk});
        chk("oe_n_rst", 32'h1, {31'h0, oe_n});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : t_reset

    task t_tune;
        wr(wgc_pkg::IDX_TW_HIGH, 16'hA5C3);
        wr(wgc_pkg::IDX_TW_LOW, 16'h7E11);
        wr(wgc_pkg::IDX_PHASE, 16'hBEEF);
        idle();
        chk("tuning", 32'hA5C37E, {8'h0, tw});
        chk("phase_out", 32'hBEEF, {16'h0, ph});
        rdchk("tw_low", wgc_pkg::IDX_TW_LOW, 16'h7E11);
        // An all-ones memory word lands four places down, under the top nibble.
        wr(wgc_pkg::IDX_MERGE_CFG, 16'h0004);
        wr(wgc_pkg::IDX_SYNTH_CFG, 16'h0003);
        mem <= 14'h3FFF;
        idle();
        chk("tw_merged", 32'hAFFFC0, {8'h0, tw});
        chk("phase_mem", 32'hFFFC, {16'h0, ph});
    endtask : t_tune

    task t_manual;
        wr(wgc_pkg::IDX_PIN_CTRL, 16'h0001);
        wr(wgc_pkg::IDX_MARK_CFG, 16'h0020);
        idle();
        chk("man_level", 32'h1, {31'h0, mk});
        chk("man_oe_n", 32'h0, {31'h0, oe_n});
        wr(wgc_pkg::IDX_MARK_CFG, 16'h0030);
        idle();
        chk("auto_ignores_level", 32'h0, {31'h0, mk});
        wr(wgc_pkg::IDX_MARK_CFG, 16'h0020);
        wr(wgc_pkg::IDX_PIN_CTRL, 16'h0000);
        idle();
        chk("pin_off_oe_n", 32'h1, {31'h0, oe_n});
        chk("pin_off_mk", 32'h0, {31'h0, mk});
    endtask : t_manual

    task t_auto;
        wr(wgc_pkg::IDX_PIN_CTRL, 16'h0001);
        wr(wgc_pkg::IDX_MARK_CFG, 16'h0014);
        idle();
        chk("auto_idle", 32'h0, {31'h0, mk});
        @(posedge clk);
        trig_n <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mk !== 1'b1 && n < 12);
        // Three synchroniser edges, plus one of skew, plus the start delay of three.
        chk("rise_window", 32'h1, {31'h0, (n >= 5 && n <= 8)});
        chk("auto_oe_n", 32'h0, {31'h0, oe_n});
        @(posedge clk);
        trig_n <= 1'b1;
        pend <= 1'b1;
        @(posedge clk);
        pend <= 1'b0;
        n = 0;
        @(negedge clk);
        while (mk === 1'b1 && n < 12) begin
            n++;
            @(negedge clk);
        end
        chk("stop_high_cycles", 32'h3, n);
    endtask : t_auto

    task t_source;
        wr(wgc_pkg::IDX_CONST, 16'hABC5);
        wr(wgc_pkg::IDX_GAIN, 16'h8F75);
        wr(wgc_pkg::IDX_WAVE_CFG, 16'h0101);
        idle();
        chk("const_sample", 32'h2AF0, {18'h0, smp});
        chk("gain_out", 32'h8F7, {20'h0, gain});
        rdchk("const_rb", wgc_pkg::IDX_CONST, 16'hABC5);
        wr(wgc_pkg::IDX_WAVE_CFG, 16'h0131);
        idle();
        chk("synth_sample", 32'h1234, {18'h0, smp});
        wr(wgc_pkg::IDX_SYNTH_CFG, 16'h000C);
        idle();
        chk("cos_sel", 32'h1, {31'h0, cos});
        chk("sram_clk", 32'h1, {31'h0, sclk});
    endtask : t_source

    task t_ramp;
        wr(wgc_pkg::IDX_WAVE_CFG, 16'h0111);
        wr(wgc_pkg::IDX_RAMP_CFG, 16'h0113);
        idle();
        chk("ramp_zero", 32'h0, {18'h0, smp});
        wr(wgc_pkg::IDX_RAMP_CFG, 16'h0111);
        idle();
        s0 = smp;
        repeat (8) @(negedge clk);
        chk("ramp_down", {18'h0, s0 - 14'h0002}, {18'h0, smp});
        // The up ramp is left running, so no step-hold check is cut short by a new shape.
        wr(wgc_pkg::IDX_RAMP_CFG, 16'h0110);
        idle();
        s0 = smp;
        n = 0;
        repeat (8) begin
            s1 = smp;
            @(negedge clk);
            if (smp !== s1) n++;
        end
        chk("ramp_steps", 32'h2, n);
        chk("ramp_up", {18'h0, s0 + 14'h0002}, {18'h0, smp});
        wr(wgc_pkg::IDX_WAVE_CFG, 16'h0121);
        idle();
        s0 = smp;
        s1 = {s0[12:0], s0[13] ^ s0[12] ^ s0[11] ^ s0[1]};
        @(negedge clk);
        chk("prbs", {18'h0, s1}, {18'h0, smp});
    endtask : t_ramp

    task t_trig;
        wr(wgc_pkg::IDX_TRIG_CTL, 16'h0002);
        idle();
        chk("first_only", 32'h0, {31'h0, sde});
        @(posedge clk);
        trig_n <= 1'b0;
        repeat (8) @(negedge clk);
        chk("first_armed", 32'h1, {31'h0, sde});
        @(posedge clk);
        trig_n <= 1'b1;
        pend <= 1'b1;
        @(posedge clk);
        pend <= 1'b0;
        idle();
        chk("first_done", 32'h0, {31'h0, sde});
        wr(wgc_pkg::IDX_TRIG_CTL, 16'h0000);
        idle();
        chk("every_pattern", 32'h1, {31'h0, sde});
        wr(8'h01, 16'hFFFF);
        rdchk("unmapped", 8'h01, 16'h0000);
    endtask : t_trig

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_tune();
        t_manual();
        t_auto();
        t_source();
        t_ramp();
        t_trig();
        // A second reset in mid-run must bring registers and outputs back.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        print_verdict();
    end
endmodule : tb_wgc_top
